// *** swl_consts.svh ***
`ifndef SWL_CONSTS_SVH
`define SWL_CONSTS_SVH
// -----------------------------------------
// indirect window word selects
// -----------------------------------------
`define SWL_SEL_CTRL 3'h0
`define SWL_SEL_TOP 3'h1
`define SWL_SEL_C 3'h2
`define SWL_SEL_B 3'h3
`define SWL_SEL_HI 3'h4
`define SWL_SEL_LO 3'h5
// -----------------------------------------
// control word fields
// -----------------------------------------
`define SWL_CTRL_RD_BIT 12
`define SWL_CTRL_TBL_MSB 11
`define SWL_CTRL_TBL_LSB 10
`define SWL_TBL_STATIC 2'h0
`define SWL_TBL_VLAN 2'h1
`define SWL_TBL_DYN 2'h2
`define SWL_TBL_MIB 2'h3
`define SWL_MIB_DROP_BASE 10'h100
`define SWL_MIB_DROP_NUM 6
// -----------------------------------------
// status bits inside data words, and the vlan mode bit of global_control_two
// -----------------------------------------
`define SWL_MIB_OVF_BIT 15
`define SWL_MIB_VLD_BIT 14
`define SWL_DYN_NRDY_BIT 7
`define SWL_VLAN_MODE_BIT 15
// -----------------------------------------
// reset values and codes
// -----------------------------------------
`define SWL_VLAN_RST 20'hf0001
`define SWL_FWD_ALL 3'h7
`define SWL_AGE_MAX 2'h3
// -----------------------------------------
// timing
// -----------------------------------------
`define SWL_CLK_MHZ 50
`define SWL_AGE_STEP_US 1000
`define SWL_AGE_STEP_CYC (`SWL_AGE_STEP_US * `SWL_CLK_MHZ)
// -----------------------------------------
// host controller register offsets
// -----------------------------------------
`define SWL_HREG_CTRL 8'h00
`define SWL_HREG_STAT 8'h18
`endif

// *** swl_pkg.sv ***
package swl_pkg;
  typedef enum logic [1:0] {D_IDLE = 2'b00, D_EXEC = 2'b01, D_ACK = 2'b11} swl_dstate_e;
  typedef enum logic [1:0] {H_IDLE = 2'b00, H_WORD = 2'b01, H_CTRL = 2'b11} swl_hstate_e;
  typedef logic [15:0] swl_word_t;
  typedef logic [2:0] swl_pmap_t;
  typedef logic [2:0] swl_sel_t;
endpackage

// *** swl_if.sv ***
`timescale 1ns/100ps
// indirect access window between host processor and switch
interface swl_if;
  logic req; // request held until ack
  logic we; // write when high
  logic [2:0] sel; // word select
  logic [15:0] wdata; // write data
  logic [15:0] rdata; // read data, valid with ack
  logic ack; // one-cycle answer
  modport dev (input req, input we, input sel, input wdata, output rdata, output ack);
  modport host (output req, output we, output sel, output wdata, input rdata, input ack);
endinterface

// *** swl_static_match.sv ***
`timescale 1ns/100ps
`include "swl_consts.svh"
module swl_static_match #(
  parameter int N = 8
) (
  input wire logic [N*58-1:0] entries, // flattened static entries
  input wire logic [47:0] mac, // destination address
  input wire logic [3:0] filter_id, // filter id of the frame
  output logic hit, // some entry matched
  output swl_pkg::swl_pmap_t fwd, // forwarding bitmap of the match
  output logic ovr // matched entry carries override
);
  import swl_pkg::*;
  logic [N-1:0] match;

  // -----------------------------------------
  // per-entry compare
  // -----------------------------------------
  genvar i;
  generate
    for (i = 0; i < N; i++)
    begin : g_ent
      wire [57:0] e = entries[i*58 +: 58];
      wire active = e[51] | e[52];
      wire fid_ok = !e[53] || (e[57:54] == filter_id);
      assign match[i] = active && fid_ok && (e[47:0] == mac);
    end
  endgenerate

  // lowest index wins when several match
  always_comb
  begin
    hit = 1'b0;
    fwd = 3'h0;
    ovr = 1'b0;
    for (int k = N - 1; k >= 0; k--)
    begin
      if (match[k])
      begin
        hit = 1'b1;
        fwd = entries[k*58+48 +: 3];
        ovr = entries[k*58+52];
      end
    end
  end
endmodule

// *** swl_dev_end.sv ***
`timescale 1ns/100ps
`include "swl_consts.svh"
module swl_dev_end #(
  parameter int AGE_STEP_CYC = `SWL_AGE_STEP_CYC,
  parameter int ST_N = 8
) (
  input wire logic clk_sys, // switch clock
  input wire logic rst, // synchronous reset
  swl_if.dev bus, // indirect access window
  input wire logic lk_req, // frame lookup request
  input wire logic [1:0] lk_ingress, // ingress port 0..2
  input wire logic lk_tagged, // frame carries a vlan tag
  input wire logic [11:0] lk_tag_vid, // vid from the tag
  input wire logic [47:0] lk_da, // destination address
  input wire logic [47:0] lk_sa, // source address
  input wire logic [35:0] port_pvid, // default vid per port
  input wire logic [2:0] port_tx_en, // transmit enable per port
  input wire logic [2:0] port_rx_en, // receive enable per port
  input wire logic [15:0] global_control_two, // bit 15 vlan mode
  input wire logic mib_inc, // per-port counter event
  input wire logic [1:0] mib_port, // port of the event
  input wire logic [4:0] mib_idx, // counter index
  input wire logic [5:0] drop_inc, // dropped-packet events
  output logic lk_done, // lookup result valid
  output swl_pkg::swl_pmap_t lk_fwd, // egress port bitmap
  output logic lk_drop // frame dropped
);
  import swl_pkg::*;

  swl_dstate_e st_r;
  logic ack_r;
  logic [15:0] rdata_r;
  logic [15:0] wd_r [0:5];
  logic [57:0] st_tbl_r [0:ST_N-1];
  logic [19:0] vl_tbl_r [0:15];
  logic [56:0] dy_tbl_r [0:1023];
  logic [30:0] mib_r [0:95];
  logic [15:0] drp_r [0:5];
  logic [10:0] dy_cnt_r;
  logic [9:0] age_ptr_r;
  logic [31:0] age_tmr_r;
  logic [ST_N*58-1:0] st_flat;
  logic [15:0] rw [1:5];

  function automatic logic [9:0] swl_hash(input logic [3:0] f, input logic [47:0] m);
    swl_hash = m[9:0] ^ m[19:10] ^ m[29:20] ^ m[39:30] ^ {2'h0, m[47:40]} ^ {f, 6'h00};
  endfunction

  // -----------------------------------------
  // indirect window decode
  // -----------------------------------------
  wire bus_new = bus.req && !ack_r && (st_r == D_IDLE);
  wire [15:0] ctrl = wd_r[0];
  wire op_rd = ctrl[`SWL_CTRL_RD_BIT];
  wire [1:0] op_tbl = ctrl[`SWL_CTRL_TBL_MSB:`SWL_CTRL_TBL_LSB];
  wire [9:0] op_addr = ctrl[9:0];
  wire op_exec = (st_r == D_EXEC);
  wire op_drop = (op_addr >= `SWL_MIB_DROP_BASE);
  wire [9:0] drp_idx = op_addr - `SWL_MIB_DROP_BASE;
  wire [6:0] mib_sel = op_addr[6:0];
  wire mib_clr_go = op_exec && op_rd && (op_tbl == `SWL_TBL_MIB) && !op_drop && !op_addr[7];
  assign bus.ack = ack_r;
  assign bus.rdata = rdata_r;

  // control write held off until the table access is done
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      st_r <= D_IDLE;
      ack_r <= 1'b0;
      rdata_r <= 16'h0000;
      for (int k = 0; k < 6; k++)
        wd_r[k] <= 16'h0000;
    end
    else
    begin
      ack_r <= 1'b0;
      case (st_r)
        D_IDLE:
          if (bus_new && bus.we && (bus.sel == `SWL_SEL_CTRL))
          begin
            wd_r[0] <= bus.wdata;
            st_r <= D_EXEC;
          end
          else if (bus_new)
          begin
            if (bus.we && (bus.sel <= `SWL_SEL_LO))
              wd_r[bus.sel] <= bus.wdata;
            rdata_r <= (bus.sel <= `SWL_SEL_LO) ? wd_r[bus.sel] : 16'h0000;
            ack_r <= 1'b1;
          end
        D_EXEC:
        begin
          if (op_rd)
            for (int k = 1; k < 6; k++)
              wd_r[k] <= rw[k];
          st_r <= D_ACK;
          ack_r <= 1'b1;
        end
        D_ACK: st_r <= D_IDLE;
        default: st_r <= D_IDLE;
      endcase
    end
  end

  // -----------------------------------------
  // readout words per table
  // -----------------------------------------
  wire [57:0] st_e = st_tbl_r[op_addr[2:0]];
  wire [19:0] vl_e = vl_tbl_r[op_addr[3:0]];
  wire [56:0] dy_e = dy_tbl_r[op_addr];
  wire [30:0] mib_e = mib_r[(mib_sel < 7'd96) ? mib_sel : 7'd0];
  wire [15:0] drp_e = drp_r[(drp_idx < 10'd6) ? drp_idx[2:0] : 3'd0];
  wire dy_empty = (dy_cnt_r == 11'h000);
  wire [9:0] dy_cntf = dy_empty ? 10'h000 : 10'(dy_cnt_r - 11'h001);
  logic dy_nrdy;

  always_comb
  begin
    for (int k = 1; k < 6; k++)
      rw[k] = 16'h0000;
    case (op_tbl)
      `SWL_TBL_STATIC:
      begin
        rw[2] = {6'h00, st_e[57:48]};
        rw[3] = st_e[47:32];
        rw[4] = st_e[31:16];
        rw[5] = st_e[15:0];
      end
      `SWL_TBL_VLAN:
      begin
        rw[4] = {12'h000, vl_e[19:16]};
        rw[5] = vl_e[15:0];
      end
      `SWL_TBL_DYN:
      begin
        rw[1] = {8'h00, dy_nrdy, 4'h0, dy_empty, dy_cntf[9:8]};
        rw[2] = {dy_cntf[7:0], dy_e[55:48]};
        rw[3] = dy_e[47:32];
        rw[4] = dy_e[31:16];
        rw[5] = dy_e[15:0];
      end
      default:
        if (op_drop)
          rw[5] = (drp_idx < 10'd6) ? drp_e : 16'h0000;
        else if (mib_sel < 7'd96 && !op_addr[7])
        begin
          rw[4] = {mib_e[30], 1'b1, mib_e[29:16]};
          rw[5] = mib_e[15:0];
        end
    endcase
  end

  // -----------------------------------------
  // static and vlan tables, host writable
  // -----------------------------------------
  wire tbl_wr = op_exec && !op_rd;
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      for (int k = 0; k < ST_N; k++)
        st_tbl_r[k] <= 58'h0;
      for (int k = 0; k < 16; k++)
        vl_tbl_r[k] <= `SWL_VLAN_RST;
    end
    else if (tbl_wr && op_tbl == `SWL_TBL_STATIC)
      st_tbl_r[op_addr[2:0]] <= {wd_r[2][9:0], wd_r[3], wd_r[4], wd_r[5]};
    else if (tbl_wr && op_tbl == `SWL_TBL_VLAN)
      vl_tbl_r[op_addr[3:0]] <= {wd_r[4][3:0], wd_r[5]};
  end

  // -----------------------------------------
  // statistics counters
  // -----------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < 96; gi++)
    begin : g_mib
      wire inc = mib_inc && ({mib_port, mib_idx} == 7'(gi));
      wire clr = mib_clr_go && (mib_sel == 7'(gi));
      always_ff @(posedge clk_sys)
      begin
        if (rst)
          mib_r[gi] <= 31'h0;
        else if (clr)
          mib_r[gi] <= {30'h0, inc}; // read clears, event still counted
        else if (inc)
          mib_r[gi] <= {mib_r[gi][30] | (&mib_r[gi][29:0]), 30'(mib_r[gi][29:0] + 30'h1)};
      end
    end
    for (gi = 0; gi < `SWL_MIB_DROP_NUM; gi++)
    begin : g_drp
      // wraps silently, no overflow flag kept
      always_ff @(posedge clk_sys)
      begin
        if (rst)
          drp_r[gi] <= 16'h0000;
        else if (drop_inc[gi])
          drp_r[gi] <= 16'(drp_r[gi] + 16'h0001);
      end
    end
    for (gi = 0; gi < ST_N; gi++)
    begin : g_flat
      assign st_flat[gi*58 +: 58] = st_tbl_r[gi];
    end
  endgenerate

  // -----------------------------------------
  // frame lookup
  // -----------------------------------------
  wire vlan_mode = global_control_two[`SWL_VLAN_MODE_BIT];
  wire [11:0] pvid = (lk_ingress == 2'h1) ? port_pvid[23:12] :
                     (lk_ingress == 2'h2) ? port_pvid[35:24] : port_pvid[11:0];
  wire [11:0] vid = (!lk_tagged || lk_tag_vid == 12'h000) ? pvid : lk_tag_vid;
  logic vl_hit;
  logic [19:0] vl_ent;
  always_comb
  begin
    vl_hit = 1'b0;
    vl_ent = 20'h0;
    for (int k = 15; k >= 0; k--)
    begin
      if (vl_tbl_r[k][11:0] == vid)
      begin
        vl_hit = 1'b1;
        vl_ent = vl_tbl_r[k];
      end
    end
  end
  wire vl_ok = !vlan_mode || (vl_hit && vl_ent[19]);
  wire [3:0] filter_id = vlan_mode ? vl_ent[15:12] : 4'h0;
  wire [2:0] members = vlan_mode ? vl_ent[18:16] : `SWL_FWD_ALL;
  wire [2:0] ing_oh = 3'(3'h1 << lk_ingress);
  logic st_hit;
  logic [2:0] st_fwd;
  logic st_ovr;
  swl_static_match #(.N(ST_N)) u_match (
    .entries(st_flat),
    .mac(lk_da),
    .filter_id(filter_id),
    .hit(st_hit),
    .fwd(st_fwd),
    .ovr(st_ovr)
  );
  wire [9:0] da_idx = swl_hash(filter_id, lk_da);
  wire [56:0] da_e = dy_tbl_r[da_idx];
  wire dy_hit = da_e[56] && (da_e[51:48] == filter_id) && (da_e[47:0] == lk_da);
  wire [2:0] dy_fwd = 3'(3'h1 << da_e[53:52]);
  wire [2:0] st_map = (st_fwd == `SWL_FWD_ALL) ? (st_fwd & ~ing_oh) : st_fwd;
  wire [2:0] fwd_raw = st_hit ? st_map : dy_hit ? dy_fwd : (members & ~ing_oh);
  wire force_fwd = st_hit && st_ovr;
  wire [2:0] fwd_out = force_fwd ? fwd_raw : (fwd_raw & port_tx_en);
  wire drop = !vl_ok || (!port_rx_en[lk_ingress] && !force_fwd);

  // result straight from flip-flops
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      lk_done <= 1'b0;
      lk_fwd <= 3'h0;
      lk_drop <= 1'b0;
    end
    else
    begin
      lk_done <= lk_req;
      lk_fwd <= (lk_req && !drop) ? fwd_out : 3'h0;
      lk_drop <= lk_req && drop;
    end
  end

  // -----------------------------------------
  // learning and aging of the dynamic table
  // -----------------------------------------
  wire [9:0] sa_idx = swl_hash(filter_id, lk_sa);
  wire [56:0] sa_e = dy_tbl_r[sa_idx];
  wire learn_we = lk_req && vl_ok && (lk_ingress != 2'h3);
  wire age_tick = (age_tmr_r == 32'(AGE_STEP_CYC - 1));
  wire [56:0] ag_e = dy_tbl_r[age_ptr_r];
  wire age_we = age_tick && ag_e[56] && !(learn_we && sa_idx == age_ptr_r);
  wire age_kill = age_we && (ag_e[55:54] == 2'h0);
  assign dy_nrdy = learn_we && (sa_idx == op_addr);

  // only the dynamic table ages; static entries are untouched here
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      for (int k = 0; k < 1024; k++)
        dy_tbl_r[k] <= 57'h0;
      dy_cnt_r <= 11'h000;
      age_ptr_r <= 10'h000;
      age_tmr_r <= 32'h0;
    end
    else
    begin
      age_tmr_r <= age_tick ? 32'h0 : 32'(age_tmr_r + 32'h1);
      if (age_tick)
        age_ptr_r <= 10'(age_ptr_r + 10'h001);
      if (learn_we)
        dy_tbl_r[sa_idx] <= {1'b1, `SWL_AGE_MAX, lk_ingress, filter_id, lk_sa};
      if (age_we)
        dy_tbl_r[age_ptr_r] <= {!age_kill, 2'(ag_e[55:54] - 2'h1), ag_e[53:0]};
      if (learn_we && !sa_e[56] && !age_kill)
        dy_cnt_r <= 11'(dy_cnt_r + 11'h001);
      else if (age_kill && !(learn_we && !sa_e[56]))
        dy_cnt_r <= 11'(dy_cnt_r - 11'h001);
    end
  end
endmodule

// *** swl_host_end.sv ***
`timescale 1ns/100ps
`include "swl_consts.svh"
module swl_host_end (
  input wire logic clk_sys, // system clock
  input wire logic rst, // synchronous reset
  input wire logic wb_cyc_i, // wishbone cycle
  input wire logic wb_stb_i, // wishbone strobe
  input wire logic wb_we_i, // wishbone write
  input wire logic [7:0] wb_adr_i, // byte address
  input wire logic [3:0] wb_sel_i, // byte lanes
  input wire logic [31:0] wb_dat_i, // write data
  output logic [31:0] wb_dat_o, // read data
  output logic wb_ack_o, // wishbone ack
  swl_if.host bus // indirect access window
);
  import swl_pkg::*;

  swl_hstate_e ph_r;
  logic [15:0] hd_r [0:5];
  logic busy_r;
  logic done_r;
  logic [2:0] widx_r;
  logic req_r;
  logic we_r;
  swl_sel_t sel_r;
  logic [15:0] wdata_r;

  // -----------------------------------------
  // decode
  // -----------------------------------------
  wire wb_go = wb_cyc_i && wb_stb_i && !wb_ack_o;
  wire [2:0] ridx = wb_adr_i[4:2];
  wire reg_hit = (wb_adr_i[7:5] == 3'h0) && (wb_adr_i[1:0] == 2'h0) && (ridx <= 3'h5);
  wire stat_hit = (wb_adr_i == `SWL_HREG_STAT);
  wire [15:0] wmask = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  wire wr_reg = wb_go && wb_we_i && reg_hit && !busy_r;
  wire [15:0] wr_val = (hd_r[ridx] & ~wmask) | (wb_dat_i[15:0] & wmask);
  wire start = wr_reg && (wb_adr_i == `SWL_HREG_CTRL);
  wire [15:0] cmd = start ? wr_val : hd_r[0];
  wire rd_op = cmd[`SWL_CTRL_RD_BIT];
  wire [1:0] tbl = cmd[`SWL_CTRL_TBL_MSB:`SWL_CTRL_TBL_LSB];
  wire mib_drop = (cmd[9:0] >= `SWL_MIB_DROP_BASE);
  // first data word of each access: top, c, b, hi, lo run 0..4
  wire [2:0] w_first = (tbl == `SWL_TBL_DYN) ? 3'h0 : (tbl == `SWL_TBL_STATIC) ? 3'h1 :
                       (tbl == `SWL_TBL_MIB && mib_drop) ? 3'h4 : 3'h3;
  wire got = req_r && bus.ack;
  wire [2:0] cur_sel = 3'(widx_r + 3'h1);
  // re-read while the device flags the word stale
  wire retry = rd_op && ((widx_r == 3'h0 && bus.rdata[`SWL_DYN_NRDY_BIT]) ||
               (tbl == `SWL_TBL_MIB && !mib_drop && widx_r == 3'h3 &&
               !bus.rdata[`SWL_MIB_VLD_BIT]));
  assign bus.req = req_r;
  assign bus.we = we_r;
  assign bus.sel = sel_r;
  assign bus.wdata = wdata_r;

  // wishbone slave, one wait state, unmapped reads zero
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
    end
    else
    begin
      wb_ack_o <= wb_go;
      wb_dat_o <= stat_hit ? {30'h0, done_r, busy_r} : reg_hit ? {16'h0, hd_r[ridx]} : 32'h0;
    end
  end

  // -----------------------------------------
  // access sequencer
  // -----------------------------------------
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      ph_r <= H_IDLE;
      busy_r <= 1'b0;
      done_r <= 1'b0;
      widx_r <= 3'h0;
      req_r <= 1'b0;
      we_r <= 1'b0;
      sel_r <= `SWL_SEL_CTRL;
      wdata_r <= 16'h0000;
      for (int k = 0; k < 6; k++)
        hd_r[k] <= 16'h0000;
    end
    else
    begin
      if (wr_reg)
        hd_r[ridx] <= wr_val;
      if (start)
      begin
        busy_r <= 1'b1;
        done_r <= 1'b0;
        widx_r <= w_first;
        ph_r <= rd_op ? H_CTRL : H_WORD; // writes load words first
      end
      else if (got)
      begin
        req_r <= 1'b0;
        if (ph_r == H_CTRL && rd_op)
          ph_r <= H_WORD;
        else if (ph_r == H_CTRL)
        begin
          ph_r <= H_IDLE;
          busy_r <= 1'b0;
          done_r <= 1'b1;
        end
        else
        begin
          if (rd_op)
            hd_r[cur_sel] <= bus.rdata;
          if (retry)
            ph_r <= H_CTRL; // a plain re-read returns the same word: rerun the access
          else if (widx_r != 3'h4)
            widx_r <= 3'(widx_r + 3'h1);
          else if (rd_op)
          begin
            ph_r <= H_IDLE;
            busy_r <= 1'b0;
            done_r <= 1'b1;
          end
          else
            ph_r <= H_CTRL;
        end
      end
      else if (!req_r && ph_r != H_IDLE)
      begin
        req_r <= 1'b1;
        we_r <= (ph_r == H_CTRL) || !rd_op;
        sel_r <= (ph_r == H_CTRL) ? `SWL_SEL_CTRL : cur_sel;
        wdata_r <= (ph_r == H_CTRL) ? hd_r[0] : hd_r[cur_sel];
      end
    end
  end
endmodule

// *** swl_monitor.sv ***
`timescale 1ns/100ps
`include "swl_consts.svh"
// ----
// indirect window checker
// ----
module swl_monitor (
  input wire logic clk_sys, // switch clock
  input wire logic rst, // synchronous reset
  input wire logic req, // host request
  input wire logic we, // write when high
  input wire logic [2:0] sel, // word select
  input wire logic [15:0] wdata, // write data
  input wire logic ack // device answer
);
  // finished control writes and the operation they carry
  wire ctl_done = ack && we && sel == `SWL_SEL_CTRL;
  wire [4:0] ctl_op = wdata[12:8];
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);
  // handshake shape and latency
  a_ack_pulse: assert property (ack |=> !ack)
    else $error("ack held past one cycle");
  a_ack_has_req: assert property (ack |-> req)
    else $error("ack without request");
  a_req_held: assert property (req && !ack |=> req && $stable({we, sel, wdata}))
    else $error("request changed before ack");
  a_ctl_wait: assert property ($rose(req) && we && sel == 3'h0 |=> !ack ##1 ack)
    else $error("control word not answered after the access");
  a_word_wait: assert property ($rose(req) && sel != 3'h0 |=> ack)
    else $error("data word not answered next cycle");
  a_req_release: assert property (ack |=> !req)
    else $error("request kept after ack");
  // read orders after a control word; the bound covers the idle gap
  a_static_order: assert property (ctl_done && ctl_op[4:2] == 3'b100 |=>
    !req ##[1:8] ($rose(req) && sel == `SWL_SEL_C))
    else $error("static read did not start at bits 57:48");
  a_dyn_top: assert property (ctl_done && ctl_op[4:2] == 3'b110 |=>
    !req ##[1:8] ($rose(req) && sel == `SWL_SEL_TOP))
    else $error("dynamic read did not start at top word");
  a_cnt_high: assert property (ctl_done && ctl_op == 5'h1c |=>
    !req ##[1:8] ($rose(req) && sel == `SWL_SEL_HI))
    else $error("port counter read did not start high");
  a_drop_low: assert property (ctl_done && ctl_op == 5'h1d |=>
    !req ##[1:8] ($rose(req) && sel == `SWL_SEL_LO))
    else $error("dropped counter read not low word");
endmodule

// *** switch_lookup_tables_access_tb.sv ***
`timescale 1ns/100ps
module switch_lookup_tables_access_tb;
  import swl_pkg::*;
  logic clk_sys, rst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [7:0] wb_adr_i;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o;
  logic lk_req, lk_tagged, lk_done, lk_drop, mib_inc;
  logic [1:0] lk_ingress, mib_port;
  logic [11:0] lk_tag_vid;
  logic [47:0] lk_da, lk_sa;
  logic [4:0] mib_idx;
  logic [5:0] drop_inc;
  swl_pmap_t lk_fwd;
  logic [15:0] rd;
  logic [2:0] tx_en, rx_en;
  logic [15:0] gc2;
  logic [15:0] st_c [7];
  logic [2:0] st_f [7];
  logic [15:0] w [4];
  int err_count, check_count;
  // ----
  // both ends joined by the window
  // ----
  swl_if bus_if();
  swl_host_end swl_host_end_i (.clk_sys, .rst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
    .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .bus(bus_if));
  // every port default vid 1; vlan mode and port enables come from the bench
  swl_dev_end swl_dev_end_i (.clk_sys, .rst, .bus(bus_if), .lk_req, .lk_ingress,
    .lk_tagged, .lk_tag_vid, .lk_da, .lk_sa, .port_pvid(36'h001001001),
    .port_tx_en(tx_en), .port_rx_en(rx_en), .global_control_two(gc2), .mib_inc,
    .mib_port, .mib_idx, .drop_inc, .lk_done, .lk_fwd, .lk_drop);
  swl_monitor swl_monitor_i (.clk_sys, .rst, .req(bus_if.req), .we(bus_if.we),
    .sel(bus_if.sel), .wdata(bus_if.wdata), .ack(bus_if.ack));
  // ----
  // helpers
  // ----
  task automatic conclude;
    if (err_count == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic hang;
    err_count++;
    conclude();
  endtask
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      err_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // classic single cycle, held until ack
  task automatic wb(input logic wr, input logic [7:0] a, input logic [15:0] d);
    int n;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= wr;
    wb_adr_i <= a;
    wb_dat_i <= {16'h0, d};
    n = 0;
    do
    begin
      @(posedge clk_sys);
      n++;
    end
    while (wb_ack_o !== 1'b1 && n < 40);
    if (wb_ack_o !== 1'b1)
      hang();
    rd = wb_dat_o[15:0];
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [15:0] e, input logic [15:0] m = '1);
    wb(1'b0, a, 16'h0);
    chk(rd & m, e);
  endtask
  // control word, then wait for done without busy
  task automatic ctl(input logic [15:0] c);
    wb(1'b1, 8'h00, c);
    for (int n = 0; n < 40; n++)
    begin
      wb(1'b0, 8'h18, 16'h0);
      if (rd[1:0] == 2'b10)
        return;
    end
    hang();
  endtask
  task automatic lk(input logic [1:0] ing, input logic tg, input logic [11:0] vid,
    input logic [47:0] da, input logic [47:0] sa, input logic dr, input logic [2:0] f);
    lk_ingress <= ing;
    lk_tagged <= tg;
    lk_tag_vid <= vid;
    lk_da <= da;
    lk_sa <= sa;
    lk_req <= 1'b1;
    @(posedge clk_sys);
    lk_req <= 1'b0;
    #1;
    chk(16'({lk_done, lk_drop}), 16'({1'b1, dr}));
    if (!dr)
      chk(16'(lk_fwd), 16'(f));
    @(posedge clk_sys);
  endtask
  // clock
  initial
  begin
    clk_sys = 1'b0;
    forever
      #10 clk_sys = ~clk_sys;
  end
  // ----
  // main sequence
  // ----
  initial
  begin
    {rst, wb_cyc_i, wb_stb_i, wb_we_i, lk_req, lk_tagged, mib_inc} = 7'h40;
    {wb_adr_i, wb_dat_i, lk_ingress, lk_tag_vid, lk_da, lk_sa} = '0;
    {mib_port, mib_idx, drop_inc} = '0;
    wb_sel_i = 4'h3;
    {tx_en, rx_en, gc2} = {3'h7, 3'h7, 16'h8000};
    err_count = 0;
    check_count = 0;
    st_c = '{16'h02d, 16'h025, 16'h035, 16'h028, 16'h02f, 16'h0ed, 16'h0cd};
    st_f = '{3'h5, 3'h4, 3'h5, 3'h0, 3'h6, 3'h4, 3'h5};
    w = '{16'h0, 16'h0a0b, 16'h0c0d, 16'h0e0f};
    repeat (3) @(posedge clk_sys);
    rst <= 1'b0;
    rdc(8'h1c, 16'h0);
    ctl(16'h1402);
    rdc(8'h10, 16'h000f);
    rdc(8'h14, 16'h0001);
    ctl(16'h1800);
    rdc(8'h04, 16'h0004, 16'h00ff);
    lk(2'd2, 1'b1, 12'h005, 48'h5, 48'h0a0b0c0d0e0f, 1'b1, 3'h0);
    ctl(16'h1800);
    rdc(8'h04, 16'h0004, 16'h00ff);
    // learn the static address on port 3, then a null tag from port 1
    lk(2'd2, 1'b0, 12'h0, 48'h5, 48'h0a0b0c0d0e0f, 1'b0, 3'h3);
    lk(2'd0, 1'b1, 12'h0, 48'h5, 48'h1234, 1'b0, 3'h6);
    ctl(16'h1800);
    rdc(8'h04, 16'h0000, 16'h00ff);
    // static entry 7 against the learned dynamic entry
    for (int i = 0; i < 7; i++)
    begin
      w[0] = st_c[i];
      for (int j = 0; j < 4; j++)
        wb(1'b1, 8'h08 + 8'(4 * j), w[j]);
      ctl(16'h0007);
      ctl(16'h1007);
      for (int j = 0; j < 4; j++)
        rdc(8'h08 + 8'(4 * j), w[j]);
      lk(2'd0, 1'b0, 12'h0, 48'h0a0b0c0d0e0f, 48'h777, 1'b0, st_f[i]);
    end
    // port 1 enables off: plain entry is masked or dropped, override entry forces
    tx_en <= 3'h6;
    rx_en <= 3'h6;
    lk(2'd0, 1'b0, 12'h0, 48'h0a0b0c0d0e0f, 48'h777, 1'b1, 3'h0);
    lk(2'd1, 1'b0, 12'h0, 48'h0a0b0c0d0e0f, 48'h777, 1'b0, 3'h4);
    w[0] = 16'h01d;
    for (int j = 0; j < 4; j++)
      wb(1'b1, 8'h08 + 8'(4 * j), w[j]);
    ctl(16'h0007);
    lk(2'd0, 1'b0, 12'h0, 48'h0a0b0c0d0e0f, 48'h777, 1'b0, 3'h5);
    tx_en <= 3'h7;
    rx_en <= 3'h7;
    // a dynamic write is ignored; learned entry keeps port, age and count
    ctl(16'h09aa);
    ctl(16'h19aa);
    rdc(8'h08, 16'h02e0);
    rdc(8'h14, 16'h0e0f);
    // vlan mode off: an unknown vid floods instead of dropping
    gc2 <= 16'h0000;
    lk(2'd2, 1'b1, 12'h005, 48'h5, 48'h777, 1'b0, 3'h3);
    // three events on port 2 counter 0x0e and on dropped counter 0
    mib_port <= 2'h1;
    mib_idx <= 5'h0e;
    repeat (3)
    begin
      mib_inc <= 1'b1;
      drop_inc <= 6'h01;
      @(posedge clk_sys);
      mib_inc <= 1'b0;
      drop_inc <= 6'h00;
      @(posedge clk_sys);
    end
    for (int k = 0; k < 2; k++)
    begin
      ctl(16'h1c2e);
      rdc(8'h10, 16'h4000);
      rdc(8'h14, k == 0 ? 16'h0003 : 16'h0000);
      ctl(16'h1d00);
      rdc(8'h14, 16'h0003);
    end
    conclude();
  end
endmodule
